// ### pkg/desr_pkg.sv
// desr_pkg: constants and carrier types for the drive event status register bank
// assumes a single 25 MHz control clock and a parameter-id access port
package desr_pkg;

    // parameter identifiers
    localparam int ID_W = 9;
    localparam logic [ID_W-1:0] ID_HALL_WIRING_CFG = 9'h052;
    localparam logic [ID_W-1:0] ID_EVENT_STATUS = 9'h0a0;
    localparam logic [ID_W-1:0] ID_LATCHED_EVENT_STATUS = 9'h0a1;
    localparam logic [ID_W-1:0] ID_HALL_INPUT_STATE = 9'h0a2;
    localparam logic [ID_W-1:0] ID_FACTORY_TEST_PARAM = 9'h0a3;
    localparam logic [ID_W-1:0] ID_LATCHED_FAULT_STATUS = 9'h0a4;
    localparam logic [ID_W-1:0] ID_FAULT_MASK = 9'h0a7;
    localparam logic [ID_W-1:0] ID_DIN_CMD_CFG = 9'h0a8;

    // event status bit positions
    localparam int EV_LOW_W = 26;
    localparam int EV_DRIVE_FAULT = 22;
    localparam int EV_HOME_ACTIVE = 26;
    localparam int EV_IN_MOTION = 27;
    localparam int EV_VEL_WINDOW = 28;
    localparam int EV_PHASE_NOT_INIT = 29;
    localparam int EV_CMD_FAULT = 30;
    localparam int EV_RESERVED = 31;

    // digital input command configuration: allow full output
    localparam int DIN_ALLOW_FULL_OUT = 3;

    // hall wiring configuration fields
    localparam int HALL_ORDER_LSB = 0;
    localparam int HALL_INV_LSB = 4;
    localparam int HALL_W = 3;

    // latched fault bits that can never be cleared
    localparam logic [31:0] FATAL_FAULTS_DEF = 32'h0000_0003;

    // reset values
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    localparam logic [15:0] HALL_CFG_RST = 16'h0000;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [ID_W-1:0] id;
        logic [31:0] wdata;
    } desr_req_s;

    typedef struct packed {
        logic valid;
        logic err;
        logic [31:0] rdata;
    } desr_rsp_s;

    // live condition inputs from drive logic on the same clock
    typedef struct packed {
        logic [EV_LOW_W-1:0] ev_low;
        logic traj_running;
        logic pos_err_outside;
        logic vel_err_over;
        logic phase_init_done;
        logic bus_cmd_timeout;
        logic pwm_cmd_mode;
    } desr_cond_s;

endpackage

// ### verilog/desr_regs.sv
// desr_regs: event status, latched event, hall state and latched fault registers
// assumes pins (home, hall, pwm presence) are asynchronous; other conditions share mclk
`timescale 1ns/1ps

module desr_regs #(
    parameter logic [31:0] FATAL_FAULTS = desr_pkg::FATAL_FAULTS_DEF,
    parameter int SYNC_STAGES = 2
) (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // parameter access port
    input wire desr_pkg::desr_req_s req,
    output desr_pkg::desr_rsp_s rsp,
    // asynchronous pins
    input wire logic home_switch_pin,
    input wire logic [desr_pkg::HALL_W-1:0] hall_pins,
    input wire logic pwm_present_pin,
    // internal drive conditions
    input wire desr_pkg::desr_cond_s cond,
    input wire logic [31:0] fault_events,
    // state for the rest of the drive
    output logic [31:0] event_status,
    output logic [31:0] latched_fault_status,
    output logic allow_full_output
);

    // refuse settings that the logic below cannot serve
    if (SYNC_STAGES < 2) begin : g_chk_sync
        $error("desr_regs: SYNC_STAGES must be at least 2");
    end
    if (desr_pkg::HALL_INV_LSB + desr_pkg::HALL_W > 16) begin : g_chk_hall
        $error("desr_regs: hall wiring fields exceed the 16-bit register");
    end
    if (desr_pkg::EV_LOW_W != desr_pkg::EV_HOME_ACTIVE) begin : g_chk_ev
        $error("desr_regs: low event field must end below the home bit");
    end
    if (desr_pkg::HALL_W != 3) begin : g_chk_hw
        $error("desr_regs: hall ordering serves exactly three lines");
    end
    if (desr_pkg::EV_DRIVE_FAULT >= desr_pkg::EV_LOW_W) begin : g_chk_df
        $error("desr_regs: drive fault bit must lie in the low event field");
    end

    localparam int NPIN = desr_pkg::HALL_W + 2;

    // pin synchronisers; only the last stage is read by logic
    logic [NPIN-1:0] pin_sync_reg [SYNC_STAGES];
    logic [NPIN-1:0] pins_raw;
    logic [NPIN-1:0] pins_s;

    assign pins_raw = {pwm_present_pin, home_switch_pin, hall_pins};
    assign pins_s = pin_sync_reg[SYNC_STAGES-1];

    genvar gs;
    generate
        for (gs = 0; gs < SYNC_STAGES; gs++) begin : g_sync
            if (gs == 0) begin : g_first
                always_ff @(posedge mclk or negedge resetn) begin
                    if (!resetn) begin
                        pin_sync_reg[gs] <= '0;
                    end else begin
                        pin_sync_reg[gs] <= pins_raw;
                    end
                end
            end else begin : g_next
                always_ff @(posedge mclk or negedge resetn) begin
                    if (!resetn) begin
                        pin_sync_reg[gs] <= '0;
                    end else begin
                        pin_sync_reg[gs] <= pin_sync_reg[gs-1];
                    end
                end
            end
        end
    endgenerate

    logic [desr_pkg::HALL_W-1:0] hall_s;
    logic home_s;
    logic pwm_present_s;

    assign hall_s = pins_s[desr_pkg::HALL_W-1:0];
    assign home_s = pins_s[desr_pkg::HALL_W];
    assign pwm_present_s = pins_s[desr_pkg::HALL_W+1];

    // configuration registers
    logic [15:0] hall_cfg_reg;
    logic [31:0] fault_mask_reg;
    logic [31:0] din_cfg_reg;
    logic wr_hit_hall_cfg;
    logic wr_hit_mask;
    logic wr_hit_din;
    logic wr_hit_lev;
    logic wr_hit_lflt;

    // one decode of the parameter id serves all write hits
    function automatic logic id_is(input logic [desr_pkg::ID_W-1:0] id,
            input logic [desr_pkg::ID_W-1:0] target);
        return id == target;
    endfunction

    assign wr_hit_hall_cfg = req.wr && id_is(req.id, desr_pkg::ID_HALL_WIRING_CFG);
    assign wr_hit_mask = req.wr && id_is(req.id, desr_pkg::ID_FAULT_MASK);
    assign wr_hit_din = req.wr && id_is(req.id, desr_pkg::ID_DIN_CMD_CFG);
    assign wr_hit_lev = req.wr && id_is(req.id, desr_pkg::ID_LATCHED_EVENT_STATUS);
    assign wr_hit_lflt = req.wr && id_is(req.id, desr_pkg::ID_LATCHED_FAULT_STATUS);

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            hall_cfg_reg <= desr_pkg::HALL_CFG_RST;
        end else if (wr_hit_hall_cfg) begin
            hall_cfg_reg <= req.wdata[15:0];
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            fault_mask_reg <= desr_pkg::WORD_ZERO;
        end else if (wr_hit_mask) begin
            fault_mask_reg <= req.wdata;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            din_cfg_reg <= desr_pkg::WORD_ZERO;
        end else if (wr_hit_din) begin
            din_cfg_reg <= req.wdata;
        end
    end

    assign allow_full_output = din_cfg_reg[desr_pkg::DIN_ALLOW_FULL_OUT];

    // hall ordering: code 0..5 picks one of six permutations, higher codes act as 0
    function automatic logic [2:0] hall_order(input logic [2:0] h, input logic [2:0] code);
        logic [2:0] o;
        o = h;
        case (code)
            3'h1: o = {h[2], h[0], h[1]};
            3'h2: o = {h[1], h[2], h[0]};
            3'h3: o = {h[1], h[0], h[2]};
            3'h4: o = {h[0], h[2], h[1]};
            3'h5: o = {h[0], h[1], h[2]};
            default: o = h;
        endcase
        return o;
    endfunction

    logic [2:0] hall_state;
    logic [desr_pkg::HALL_W-1:0] hall_order_code;
    logic [desr_pkg::HALL_W-1:0] hall_inv_mask;
    assign hall_order_code = hall_cfg_reg[desr_pkg::HALL_ORDER_LSB +: desr_pkg::HALL_W];
    assign hall_inv_mask = hall_cfg_reg[desr_pkg::HALL_INV_LSB +: desr_pkg::HALL_W];
    assign hall_state = hall_order(hall_s, hall_order_code) ^ hall_inv_mask;

    // registered so the read mux never sees a half-applied wiring change
    logic [2:0] hall_state_reg;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            hall_state_reg <= '0;
        end else begin
            hall_state_reg <= hall_state;
        end
    end

    // write-one-to-clear update; a set in the clearing cycle wins
    function automatic logic [31:0] w1c_next(input logic [31:0] cur, input logic [31:0] clr,
            input logic [31:0] set);
        return (cur & ~clr) | set;
    endfunction

    // latched fault register; set wins over a clearing write
    logic [31:0] lflt_reg;
    logic [31:0] lflt_clear;
    assign lflt_clear = wr_hit_lflt ? (req.wdata & ~FATAL_FAULTS) : desr_pkg::WORD_ZERO;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            lflt_reg <= desr_pkg::WORD_ZERO;
        end else begin
            lflt_reg <= w1c_next(lflt_reg, lflt_clear, fault_events & fault_mask_reg);
        end
    end

    assign latched_fault_status = lflt_reg;

    // live event status
    logic [31:0] ev_next;
    logic cmd_fault;
    logic pwm_missing;

    // a quiet pwm line only matters while the drive takes its command from it
    assign pwm_missing = cond.pwm_cmd_mode && !pwm_present_s && !allow_full_output;
    assign cmd_fault = cond.bus_cmd_timeout || pwm_missing;

    always_comb begin
        ev_next = '0;
        ev_next[desr_pkg::EV_LOW_W-1:0] = cond.ev_low;
        ev_next[desr_pkg::EV_DRIVE_FAULT] = |lflt_reg;
        ev_next[desr_pkg::EV_HOME_ACTIVE] = home_s;
        ev_next[desr_pkg::EV_IN_MOTION] = cond.traj_running || cond.pos_err_outside;
        ev_next[desr_pkg::EV_VEL_WINDOW] = cond.vel_err_over;
        ev_next[desr_pkg::EV_PHASE_NOT_INIT] = !cond.phase_init_done;
        ev_next[desr_pkg::EV_CMD_FAULT] = cmd_fault;
        ev_next[desr_pkg::EV_RESERVED] = 1'b0;
    end

    // registered so a host read and the latched copy see one consistent word
    logic [31:0] ev_reg;
    localparam logic [31:0] EV_RST = 32'h0000_0001 << desr_pkg::EV_PHASE_NOT_INIT;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ev_reg <= EV_RST;
        end else begin
            ev_reg <= ev_next;
        end
    end

    assign event_status = ev_reg;

    // latched event register; an event in the clearing cycle survives
    logic [31:0] lev_reg;
    logic [31:0] lev_clear;
    assign lev_clear = wr_hit_lev ? req.wdata : desr_pkg::WORD_ZERO;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            lev_reg <= desr_pkg::WORD_ZERO;
        end else begin
            lev_reg <= w1c_next(lev_reg, lev_clear, ev_reg);
        end
    end

    // read decode; factory test parameter always reads zero
    logic [31:0] rd_mux;
    logic rd_known;
    logic wr_known;

    always_comb begin
        rd_mux = desr_pkg::WORD_ZERO;
        rd_known = 1'b1;
        if (req.id == desr_pkg::ID_EVENT_STATUS) begin
            rd_mux = ev_reg;
        end else if (req.id == desr_pkg::ID_LATCHED_EVENT_STATUS) begin
            rd_mux = lev_reg;
        end else if (req.id == desr_pkg::ID_HALL_INPUT_STATE) begin
            rd_mux = {29'h0000_0000, hall_state_reg};
        end else if (req.id == desr_pkg::ID_FACTORY_TEST_PARAM) begin
            rd_mux = desr_pkg::WORD_ZERO;
        end else if (req.id == desr_pkg::ID_LATCHED_FAULT_STATUS) begin
            rd_mux = lflt_reg;
        end else if (req.id == desr_pkg::ID_HALL_WIRING_CFG) begin
            rd_mux = {16'h0000, hall_cfg_reg};
        end else if (req.id == desr_pkg::ID_FAULT_MASK) begin
            rd_mux = fault_mask_reg;
        end else if (req.id == desr_pkg::ID_DIN_CMD_CFG) begin
            rd_mux = din_cfg_reg;
        end else begin
            rd_known = 1'b0;
        end
    end

    // read-only parameters other than the factory test parameter refuse writes with the error flag
    assign wr_known = wr_hit_hall_cfg || wr_hit_mask || wr_hit_din || wr_hit_lev
        || wr_hit_lflt || (req.id == desr_pkg::ID_FACTORY_TEST_PARAM);

    logic rd_err;
    logic wr_err;
    desr_pkg::desr_rsp_s rsp_next;

    assign rd_err = req.rd && !rd_known;
    assign wr_err = req.wr && !req.rd && !wr_known;

    always_comb begin
        rsp_next = '0;
        rsp_next.valid = req.rd || req.wr;
        rsp_next.err = rd_err || wr_err;
        rsp_next.rdata = req.rd ? rd_mux : desr_pkg::WORD_ZERO;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rsp <= '0;
        end else begin
            rsp <= rsp_next;
        end
    end

endmodule // desr_regs

// ### sim/desr_regs_sva.sv
// desr_regs_sva: port assertions for the status register bank
// assumes the ports of desr_regs and its single mclk domain
`timescale 1ns/1ps
module desr_regs_sva #(
    parameter logic [31:0] FATAL_FAULTS = desr_pkg::FATAL_FAULTS_DEF
) (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // parameter access port
    input wire desr_pkg::desr_req_s req,
    input wire desr_pkg::desr_rsp_s rsp,
    // pins and conditions
    input wire logic home_switch_pin,
    input wire desr_pkg::desr_cond_s cond,
    // state outputs
    input wire logic [31:0] event_status,
    input wire logic [31:0] latched_fault_status,
    input wire logic allow_full_output
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    // pin goes through two sync stages and the event register, hence three steady samples
    sequence s_home_steady;
        home_switch_pin [*3];
    endsequence
    sequence s_no_cmd_fault;
        allow_full_output && !cond.bus_cmd_timeout;
    endsequence
    logic clr_fault;
    assign clr_fault = req.wr && req.id == desr_pkg::ID_LATCHED_FAULT_STATUS;
    a_home_active: assert property (s_home_steady |=> event_status[26])
        else $error("home bit not set");
    a_in_motion: assert property (cond.traj_running || cond.pos_err_outside |=> event_status[27])
        else $error("motion bit not set");
    a_settled_clear: assert property (!(cond.traj_running || cond.pos_err_outside) [*2]
        |=> !event_status[27])
        else $error("motion bit stuck");
    a_vel_window: assert property (cond.vel_err_over |=> event_status[28])
        else $error("velocity bit not set");
    a_phase_pending: assert property (!cond.phase_init_done |=> event_status[29])
        else $error("phase bit not set");
    a_cmd_timeout: assert property (cond.bus_cmd_timeout |=> event_status[30])
        else $error("command fault not set");
    a_full_output: assert property (s_no_cmd_fault ##1 s_no_cmd_fault |=> !event_status[30])
        else $error("command fault despite full output");
    a_fault_sticky: assert property (!clr_fault |=> (latched_fault_status
        & $past(latched_fault_status)) == $past(latched_fault_status))
        else $error("latched fault lost");
    a_drive_fault: assert property (latched_fault_status != 32'h0 |=> event_status[22])
        else $error("drive fault bit not set");
    a_fatal_kept: assert property ((($past(latched_fault_status) & ~latched_fault_status)
        & FATAL_FAULTS) == 32'h0)
        else $error("fatal fault cleared");
    a_rsvd_zero: assert property (event_status[31] == 1'b0)
        else $error("reserved bit set");
endmodule // desr_regs_sva

bind desr_regs desr_regs_sva #(.FATAL_FAULTS(FATAL_FAULTS)) u_sva (.mclk(mclk), .resetn(resetn),
    .req(req), .rsp(rsp), .home_switch_pin(home_switch_pin), .cond(cond),
    .event_status(event_status), .latched_fault_status(latched_fault_status),
    .allow_full_output(allow_full_output));

// ### sim/desr_host.sv
// desr_host: host issuing parameter reads and writes, one at a time
// assumes the answer is registered on the taking edge and sampled 1 ns after it
`timescale 1ns/1ps
module desr_host (
    // clock
    input wire logic mclk,
    // parameter access port
    output desr_pkg::desr_req_s req,
    input wire desr_pkg::desr_rsp_s rsp
);
    initial req = '0;
    task automatic xfer(input logic w, input logic [8:0] id, input logic [31:0] d,
            output desr_pkg::desr_rsp_s r);
        @(posedge mclk);
        req <= '{rd: !w, wr: w, id: id, wdata: d};
        @(posedge mclk);
        req <= '0;
        #1 r = rsp;
        // test parameter content is never used, only its status
        if (id == desr_pkg::ID_FACTORY_TEST_PARAM) begin
            r.rdata = 32'h0;
        end
    endtask
endmodule // desr_host

// ### sim/testbench.sv
// testbench: random and directed checks of the status register bank
// assumes desr_regs with default parameters driven by the desr_host model
`timescale 1ns/1ps
module testbench;
    logic mclk = 1'b0;
    logic resetn, home, pwm, allow;
    logic [2:0] hall, x;
    logic [31:0] faults, event_status, fault_status;
    desr_pkg::desr_req_s req;
    desr_pkg::desr_rsp_s rsp, r;
    desr_pkg::desr_cond_s cond;
    integer seed, i, n_fail = 0, num_checks = 0;
    always #20 mclk = ~mclk;
    desr_host host (.mclk(mclk), .req(req), .rsp(rsp));
    desr_regs dut (.mclk(mclk), .resetn(resetn), .req(req), .rsp(rsp), .home_switch_pin(home),
        .hall_pins(hall), .pwm_present_pin(pwm), .cond(cond), .fault_events(faults),
        .event_status(event_status), .latched_fault_status(fault_status),
        .allow_full_output(allow));
    function automatic logic [31:0] ev_exp(input desr_pkg::desr_cond_s c, input logic h,
            input logic p, input logic a);
        ev_exp = {1'b0, c.bus_cmd_timeout | (c.pwm_cmd_mode & !p & !a), !c.phase_init_done,
            c.vel_err_over, c.traj_running | c.pos_err_outside, h, c.ev_low[25:23], 1'b0,
            c.ev_low[21:0]};
    endfunction
    function automatic logic [2:0] hall_exp(input logic [2:0] o, input logic [2:0] v,
            input logic [2:0] h);
        case (o)
            3'h1: hall_exp = {h[2], h[0], h[1]} ^ v;
            3'h2: hall_exp = {h[1], h[2], h[0]} ^ v;
            3'h3: hall_exp = {h[1], h[0], h[2]} ^ v;
            3'h4: hall_exp = {h[0], h[2], h[1]} ^ v;
            3'h5: hall_exp = {h[0], h[1], h[2]} ^ v;
            default: hall_exp = h ^ v;
        endcase
    endfunction
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic wr(input logic [8:0] id, input logic [31:0] d);
        host.xfer(1'b1, id, d, r);
    endtask
    task automatic rd_chk(input string what, input logic [8:0] id, input logic [31:0] e);
        host.xfer(1'b0, id, 32'h0, r);
        chk(what, e, r.rdata);
        chk({what, " valid"}, 32'h1, {31'h0, r.valid});
    endtask
    // pins need two sync stages plus the event register
    task automatic settle;
        repeat (4) @(posedge mclk);
        #1;
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        #400000;
        n_fail++;
        final_report();
    end
    initial begin
        seed = 32'h0797efb8;
        resetn = 1'b0; cond = '0; home = 1'b0; hall = 3'h0; pwm = 1'b1; faults = 32'h0;
        repeat (6) @(posedge mclk);
        resetn <= 1'b1;
        rd_chk("event reset", desr_pkg::ID_EVENT_STATUS, 32'h2000_0000);
        rd_chk("latched reset", desr_pkg::ID_LATCHED_EVENT_STATUS, 32'h2000_0000);
        for (i = 0; i < 24; i++) begin
            @(posedge mclk);
            cond <= desr_pkg::desr_cond_s'($random(seed));
            {home, pwm, hall} <= 5'($random(seed));
            faults <= $random(seed);
            settle();
            chk("event live", ev_exp(cond, home, pwm, 1'b0), event_status);
            rd_chk("event read", desr_pkg::ID_EVENT_STATUS, ev_exp(cond, home, pwm, 1'b0));
        end
        @(posedge mclk);
        cond <= desr_pkg::desr_cond_s'(32'h0000_0005);
        {home, pwm, faults} <= 34'h0;
        settle();
        chk("missing pwm", 32'h4000_0000, event_status);
        wr(desr_pkg::ID_DIN_CMD_CFG, 32'h0000_0008);
        settle();
        chk("full output", 32'h0, event_status);
        chk("full output flag", 32'h1, {31'h0, allow});
        wr(desr_pkg::ID_LATCHED_EVENT_STATUS, 32'hffff_ffff);
        rd_chk("latched all clear", desr_pkg::ID_LATCHED_EVENT_STATUS, 32'h0);
        @(posedge mclk);
        cond <= desr_pkg::desr_cond_s'(32'h0000_0025);
        @(posedge mclk);
        cond <= desr_pkg::desr_cond_s'(32'h0000_0005);
        settle();
        rd_chk("latched kept", desr_pkg::ID_LATCHED_EVENT_STATUS, 32'h0800_0000);
        wr(desr_pkg::ID_LATCHED_EVENT_STATUS, 32'h0);
        rd_chk("zero write", desr_pkg::ID_LATCHED_EVENT_STATUS, 32'h0800_0000);
        wr(desr_pkg::ID_LATCHED_EVENT_STATUS, 32'h0800_0000);
        rd_chk("one write", desr_pkg::ID_LATCHED_EVENT_STATUS, 32'h0);
        // inversion only with identity order, so the order of the two steps cannot matter
        for (i = 0; i < 8; i++) begin
            x = (i == 0) ? 3'($random(seed)) : 3'h0;
            wr(desr_pkg::ID_HALL_WIRING_CFG, {25'h0, x, 1'b0, 3'(i)});
            @(posedge mclk);
            hall <= 3'($random(seed));
            settle();
            rd_chk("hall", desr_pkg::ID_HALL_INPUT_STATE, {29'h0, hall_exp(3'(i), x, hall)});
        end
        wr(desr_pkg::ID_FAULT_MASK, 32'hffff_ffff);
        @(posedge mclk);
        faults <= 32'h0000_0105;
        @(posedge mclk);
        faults <= 32'h0;
        settle();
        chk("fault latched", 32'h0000_0105, fault_status);
        chk("drive fault", 32'h0040_0000, event_status);
        wr(desr_pkg::ID_LATCHED_FAULT_STATUS, 32'h0000_0100);
        rd_chk("fault clear", desr_pkg::ID_LATCHED_FAULT_STATUS, 32'h0000_0005);
        wr(desr_pkg::ID_LATCHED_FAULT_STATUS, 32'hffff_ffff);
        rd_chk("fatal kept", desr_pkg::ID_LATCHED_FAULT_STATUS, 32'h0000_0001);
        wr(desr_pkg::ID_EVENT_STATUS, 32'hffff_ffff);
        chk("read only write", 32'h1, {31'h0, r.err});
        wr(desr_pkg::ID_FACTORY_TEST_PARAM, 32'h1234_5678);
        chk("test param write", 32'h0, {31'h0, r.err});
        final_report();
    end
endmodule // testbench
